// ---- hdl/category_config_save.sv ----
// category configuration save: save-command entries, live objects, restore and save control
//
// Behaviour
// (RL1) restore every saveable object after each reset
// (RL2) stored copies untouched except by a save
// (RL3) only whole categories are stored, never singles
// (RL4) each saveable object has exactly one category
// (RL5) uncategorised objects never stored, start live
// (RL6) customer objects stored but hidden from functions
// (RL7) key written to a subindex starts category save
// (RL8) finished save overwrites the entry with one
// (RL9) subindex one all, two to six categories
// (RL10) host polls entry until it reads one
// (RL11) motor setup writes drive objects and saves
// (RL12) any other value starts no save
`include "category_config_save_params.svh"
`default_nettype none
module category_config_save
  import category_config_save_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_sub,
  input wire logic [31:0] cmd_wdata,
  output logic [31:0] cmd_rdata_q,
  output logic cmd_ack_q,
  input wire logic obj_wr,
  input wire logic [3:0] obj_idx,
  input wire logic [31:0] obj_wdata,
  output logic [31:0] obj_rdata_q,
  input wire logic [3:0] app_idx,
  output logic [31:0] app_data_q,
  input wire logic setup_wr,
  input wire logic [3:0] setup_idx,
  input wire logic [31:0] setup_wdata,
  input wire logic setup_save,
  output logic nv_req_q,
  output logic nv_we_q,
  output logic [3:0] nv_addr_q,
  output logic [31:0] nv_wdata_q,
  input wire logic nv_ack,
  input wire logic [31:0] nv_rdata,
  output logic cfg_ready_q,
  output logic save_busy_q
);
  ctrl_state_type ctrl_q;
  ctrl_state_type ctrl_d;
  logic [31:0] cmd_q [`SUB_COUNT];
  logic [31:0] live_q [`OBJ_COUNT];
  logic [6:0] pend_q;
  logic [6:0] pend_d;
  logic [2:0] sel_q;
  logic kick_q;
  logic [2:0] pick;
  logic walk_busy;
  logic walk_done;
  logic [3:0] walk_idx;
  logic upd_we;
  logic [3:0] upd_idx;
  logic [31:0] upd_data;

  wire [47:0] cat_tbl = `OBJ_CAT_TABLE;
  // each object index maps to exactly one category code
  wire cat_type app_cat = cat_tbl[{2'b00, app_idx} * 6'd3 +: 3]; // RL4
  wire cat_type setup_cat = cat_tbl[{2'b00, setup_idx} * 6'd3 +: 3];
  wire cat_type nv_cat = cat_tbl[{2'b00, nv_addr_q} * 6'd3 +: 3];

  // subindex decode: 01 is every category, 02..06 one category each
  wire sub_ok = (cmd_sub >= `SUB_ALL) && (cmd_sub <= `SUB_TUNE); // RL9
  wire [2:0] sub_slot = cmd_sub[2:0] - 3'h1;
  wire key_hit = cmd_wr && sub_ok && (cmd_wdata == `SAVE_KEY); // RL7
  wire in_run = (ctrl_q == ST_RUN);
  wire in_save = (ctrl_q == ST_SAVE);
  wire in_restore = (ctrl_q == ST_RESTORE);

  // a save may start only after restore, and only when the walker is free
  wire save_go = in_run && (|pend_q) && !walk_busy;
  wire walk_start = kick_q || save_go;
  // slot 0 saves all categories, slot 6 is the motor setup drive save
  wire [5:0] sel_mask = (pick == 3'h0) ? `MASK_ALL :
                        (pick == `SLOT_SETUP) ? `MASK_DRIVE :
                        (`MASK_ONE << pick); // RL9
  wire [5:0] walk_mask = kick_q ? `MASK_ALL : sel_mask;
  wire save_end = in_save && walk_done;
  wire host_same = cmd_wr && sub_ok && (sub_slot == sel_q);
  // motor setup may only touch drive objects
  wire setup_ok = setup_wr && in_run && (setup_cat == `CAT_DRIVE); // RL11
  wire host_ok = obj_wr && in_run && !setup_ok;

  // lowest pending slot wins; the whole-device save comes first
  always_comb begin
    pick = 3'h0;
    for (int i = 6; i >= 0; i--) begin
      if (pend_q[i]) begin
        pick = 3'(i);
      end
    end
  end

  // pending slots: a new key written as a save ends is kept, set beats clear
  always_comb begin
    pend_d = pend_q;
    if (save_end) begin
      pend_d[sel_q] = 1'b0;
    end
    if (key_hit) begin
      pend_d[sub_slot] = 1'b1; // RL7
    end
    if (setup_save && in_run) begin
      pend_d[`SLOT_SETUP] = 1'b1; // RL11
    end
  end

  // controller sequence: restore first, then serve saves one at a time
  always_comb begin
    ctrl_d = ctrl_q;
    case (ctrl_q)
      ST_RESTORE: if (walk_done) ctrl_d = ST_RUN; // RL1
      ST_RUN: if (save_go) ctrl_d = ST_SAVE;
      ST_SAVE: if (walk_done) ctrl_d = ST_RUN;
      default: ctrl_d = ST_RESTORE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= ST_RESTORE;
      kick_q <= 1'b1;
      pend_q <= 7'h00;
      sel_q <= 3'h0;
      cfg_ready_q <= 1'b0;
      save_busy_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      kick_q <= 1'b0;
      pend_q <= pend_d;
      if (save_go) begin
        sel_q <= pick;
      end
      cfg_ready_q <= (ctrl_d != ST_RESTORE); // RL1
      save_busy_q <= (ctrl_d == ST_SAVE) || (|pend_d);
    end
  end

  // save-command entries: any value is stored, only the key starts a save
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `SUB_COUNT; i++) begin
        cmd_q[i] <= `CMD_RESET_VAL;
      end
    end else begin
      if (save_end && (sel_q != `SLOT_SETUP) && !host_same) begin
        cmd_q[sel_q] <= `SAVE_DONE_VAL; // RL8
      end
      if (cmd_wr && sub_ok) begin
        cmd_q[sub_slot] <= cmd_wdata; // RL12
      end
    end
  end

  // register answers: one cycle after the access, unmapped reads give zero
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_rdata_q <= 32'h0;
      cmd_ack_q <= 1'b0;
    end else begin
      cmd_ack_q <= cmd_wr || cmd_rd;
      cmd_rdata_q <= sub_ok ? cmd_q[sub_slot] : 32'h0;
    end
  end

  // live objects start at reset values, so state-dependent ones stay live
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `OBJ_COUNT; i++) begin
        live_q[i] <= `LIVE_RESET_VAL; // RL5
      end
    end else begin
      if (upd_we) begin
        live_q[upd_idx] <= upd_data; // RL1
      end else if (setup_ok) begin
        live_q[setup_idx] <= setup_wdata; // RL11
      end else if (host_ok) begin
        live_q[obj_idx] <= obj_wdata;
      end
    end
  end

  // host sees every object; device functions never see customer contents
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      obj_rdata_q <= 32'h0;
      app_data_q <= 32'h0;
    end else begin
      obj_rdata_q <= live_q[obj_idx];
      app_data_q <= (app_cat == `CAT_CUST) ? 32'h0 : live_q[app_idx]; // RL6
    end
  end

  // the walker only writes storage on a save, so stored data outlives updates
  obj_walker u_walker (
    .mclk(mclk),
    .rst_b(rst_b),
    .start(walk_start),
    .restore(in_restore), // RL2
    .cat_mask(walk_mask),
    .busy(walk_busy),
    .done_q(walk_done),
    .rd_idx(walk_idx),
    .rd_data(live_q[walk_idx]),
    .nv_req_q(nv_req_q),
    .nv_we_q(nv_we_q),
    .nv_addr_q(nv_addr_q),
    .nv_wdata_q(nv_wdata_q),
    .nv_ack(nv_ack),
    .nv_rdata(nv_rdata),
    .upd_we_q(upd_we),
    .upd_idx_q(upd_idx),
    .upd_data_q(upd_data)
  );

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence save_begin_s;
    in_run && save_go;
  endsequence

  sequence drive_save_s;
    in_save && (sel_q == `SLOT_SETUP);
  endsequence

  key_starts_save_a: assert property ( // RL7
    key_hit |=> pend_q[$past(sub_slot)] || (in_save && sel_q == $past(sub_slot)))
    else $error("key write did not start a save");

  other_value_idle_a: assert property ( // RL12
    cmd_wr && sub_ok && cmd_wdata != `SAVE_KEY && !pend_q[sub_slot] && !setup_save
      |=> !pend_q[$past(sub_slot)])
    else $error("non-key write started a save");

  done_sets_one_a: assert property ( // RL8
    save_end && sel_q != `SLOT_SETUP && !cmd_wr ##1 cmd_rd && sub_slot == $past(sel_q)
      |=> cmd_rdata_q == `SAVE_DONE_VAL)
    else $error("finished save did not leave one");

  restore_no_write_a: assert property ( // RL2
    in_restore |-> !(nv_req_q && nv_we_q))
    else $error("storage written during restore");

  ready_after_restore_a: assert property ( // RL1
    in_restore && walk_done |=> cfg_ready_q ##1 cfg_ready_q)
    else $error("not ready after restore");

  customer_hidden_a: assert property ( // RL6
    app_cat == `CAT_CUST |=> app_data_q == 32'h0)
    else $error("customer object reached a device function");

  none_not_stored_a: assert property ( // RL5
    nv_req_q && nv_we_q |-> nv_cat != `CAT_NONE)
    else $error("uncategorised object stored");

  whole_group_a: assert property ( // RL3
    nv_req_q && nv_we_q && in_save && sel_q != 3'h0 && sel_q != `SLOT_SETUP
      |-> nv_cat == cat_type'(sel_q))
    else $error("object outside the selected category stored");

  setup_drive_a: assert property ( // RL11
    setup_save && in_run && pend_q == 7'h00 && !walk_busy && !key_hit
      |=> save_begin_s ##1 drive_save_s)
    else $error("motor setup save did not start");

endmodule : category_config_save
`default_nettype wire

// ---- common/category_config_save_params.svh ----
// constants for the category configuration save block
`ifndef CATEGORY_CONFIG_SAVE_PARAMS_SVH
`define CATEGORY_CONFIG_SAVE_PARAMS_SVH

// key that starts a save, and the value left behind when it ends
`define SAVE_KEY 32'h65766173
`define SAVE_DONE_VAL 32'h00000001
`define CMD_RESET_VAL 32'h00000000

// save-command subindex numbers
`define SUB_ALL 8'h01
`define SUB_COMM 8'h02
`define SUB_APP 8'h03
`define SUB_CUST 8'h04
`define SUB_DRIVE 8'h05
`define SUB_TUNE 8'h06
`define SUB_COUNT 6

// category codes of an object
`define CAT_NONE 3'h0
`define CAT_COMM 3'h1
`define CAT_APP 3'h2
`define CAT_CUST 3'h3
`define CAT_DRIVE 3'h4
`define CAT_TUNE 3'h5

// category masks, one bit per category code
`define MASK_ALL 6'h3e
`define MASK_ONE 6'h01
`define MASK_DRIVE 6'h10

// object table: 16 objects, 3-bit category each, object 0 in the low bits
`define OBJ_COUNT 16
`define OBJ_LAST 4'hf
`define OBJ_CAT_TABLE {3'h0, 3'h5, 3'h5, 3'h5, 3'h4, 3'h4, 3'h3, 3'h3, \
                       3'h2, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1, 3'h1, 3'h0}
`define LIVE_RESET_VAL 32'h00000000

// slot number used by the automatic motor setup save
`define SLOT_SETUP 3'h6

`endif

// ---- common/category_config_save_pkg.sv ----
// types shared by the category configuration save block
`default_nettype none
package category_config_save_pkg;
  typedef enum {ST_RESTORE, ST_RUN, ST_SAVE} ctrl_state_type;
  typedef enum {W_IDLE, W_SCAN, W_WAIT} walk_state_type;
  typedef logic [2:0] cat_type;
endpackage : category_config_save_pkg
`default_nettype wire

// ---- hdl/obj_walker.sv ----
// object walker: copies every object of the selected categories to or from storage
`include "category_config_save_params.svh"
`default_nettype none
module obj_walker
  import category_config_save_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic restore,
  input wire logic [5:0] cat_mask,
  output logic busy,
  output logic done_q,
  output logic [3:0] rd_idx,
  input wire logic [31:0] rd_data,
  output logic nv_req_q,
  output logic nv_we_q,
  output logic [3:0] nv_addr_q,
  output logic [31:0] nv_wdata_q,
  input wire logic nv_ack,
  input wire logic [31:0] nv_rdata,
  output logic upd_we_q,
  output logic [3:0] upd_idx_q,
  output logic [31:0] upd_data_q
);
  walk_state_type st_q;
  logic [3:0] idx_q;
  logic [5:0] mask_q;
  logic rd_mode_q;
  wire [47:0] cat_tbl = `OBJ_CAT_TABLE;
  wire cat_type cur_cat = cat_tbl[{2'b00, idx_q} * 6'd3 +: 3];
  // uncategorised objects never match, since mask bit 0 is never set
  wire hit = mask_q[cur_cat];
  wire last = (idx_q == `OBJ_LAST);

  assign busy = (st_q != W_IDLE);
  assign rd_idx = idx_q;

  // one object per visit; whole categories only, never a single object
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= W_IDLE;
      idx_q <= 4'h0;
      mask_q <= 6'h00;
      rd_mode_q <= 1'b0;
      done_q <= 1'b0;
      nv_req_q <= 1'b0;
      nv_we_q <= 1'b0;
      nv_addr_q <= 4'h0;
      nv_wdata_q <= 32'h0;
      upd_we_q <= 1'b0;
      upd_idx_q <= 4'h0;
      upd_data_q <= 32'h0;
    end else begin
      done_q <= 1'b0;
      upd_we_q <= 1'b0;
      case (st_q)
        W_IDLE: begin
          if (start) begin
            idx_q <= 4'h0;
            mask_q <= cat_mask & `MASK_ALL;
            rd_mode_q <= restore;
            st_q <= W_SCAN;
          end
        end
        W_SCAN: begin
          if (hit) begin // RL3
            nv_req_q <= 1'b1;
            nv_we_q <= ~rd_mode_q;
            nv_addr_q <= idx_q;
            nv_wdata_q <= rd_data;
            st_q <= W_WAIT;
          end else if (last) begin
            done_q <= 1'b1;
            st_q <= W_IDLE;
          end else begin
            idx_q <= idx_q + 4'h1;
          end
        end
        W_WAIT: begin
          if (nv_ack) begin
            nv_req_q <= 1'b0;
            nv_we_q <= 1'b0;
            // restore path: the stored copy lands in the live table
            upd_we_q <= rd_mode_q; // RL1
            upd_idx_q <= idx_q;
            upd_data_q <= nv_rdata;
            if (last) begin
              done_q <= 1'b1;
              st_q <= W_IDLE;
            end else begin
              idx_q <= idx_q + 4'h1;
              st_q <= W_SCAN;
            end
          end
        end
        default: st_q <= W_IDLE;
      endcase
    end
  end
endmodule : obj_walker
`default_nettype wire

// ---- bench/nv_store_model.sv ----
// behavioural non-volatile store that answers the block's storage requests
`default_nettype none
module nv_store_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic nv_req,
  input wire logic nv_we,
  input wire logic [3:0] nv_addr,
  input wire logic [31:0] nv_wdata,
  input wire logic slow,
  output logic nv_ack,
  output logic [31:0] nv_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [16];
  logic [3:0] wait_q;
  // preloaded words stand for values kept from an earlier run; reset never clears them
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 32'h5a5a0000 + i;
  end
  // one request at a time; a slow store keeps the block waiting for its answer
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      nv_ack <= 1'b0;
      wait_q <= 4'h0;
      nv_rdata <= 32'h0;
    end else if (nv_ack) begin
      nv_ack <= 1'b0;
      nv_rdata <= ~nv_rdata; // stale data must not look valid
    end else if (nv_req && wait_q >= (slow ? 4'h7 : 4'h0)) begin
      nv_ack <= 1'b1;
      wait_q <= 4'h0;
      nv_rdata <= mem[nv_addr];
      if (nv_we) mem[nv_addr] <= nv_wdata;
    end else if (nv_req) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : nv_store_model
`default_nettype wire

// ---- bench/category_config_save_tb.sv ----
// self-checking bench for the category configuration save block
`include "category_config_save_params.svh"
`default_nettype none
module category_config_save_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst_b = 1'b0, cmd_wr = 1'b0, cmd_rd = 1'b0, obj_wr = 1'b0;
  logic setup_wr = 1'b0, setup_save = 1'b0, slow = 1'b0;
  logic [7:0] cmd_sub = 8'h00;
  logic [31:0] cmd_wdata = 32'h0, obj_wdata = 32'h0, setup_wdata = 32'h0;
  logic [3:0] obj_idx = 4'h0, app_idx = 4'h0, setup_idx = 4'h0, nv_addr_q;
  logic [31:0] cmd_rdata_q, obj_rdata_q, app_data_q, nv_wdata_q, nv_rdata, rd;
  logic cmd_ack_q, nv_req_q, nv_we_q, nv_ack, cfg_ready_q, save_busy_q;
  logic [31:0] exp_mem [16];
  int err_total = 0, total_checks = 0;
  int subs [6] = '{2, 3, 4, 5, 6, 1};

  category_config_save u_dut (
    .mclk(mclk), .rst_b(rst_b), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_sub(cmd_sub),
    .cmd_wdata(cmd_wdata), .cmd_rdata_q(cmd_rdata_q), .cmd_ack_q(cmd_ack_q),
    .obj_wr(obj_wr), .obj_idx(obj_idx), .obj_wdata(obj_wdata), .obj_rdata_q(obj_rdata_q),
    .app_idx(app_idx), .app_data_q(app_data_q), .setup_wr(setup_wr),
    .setup_idx(setup_idx), .setup_wdata(setup_wdata), .setup_save(setup_save),
    .nv_req_q(nv_req_q), .nv_we_q(nv_we_q), .nv_addr_q(nv_addr_q),
    .nv_wdata_q(nv_wdata_q), .nv_ack(nv_ack), .nv_rdata(nv_rdata),
    .cfg_ready_q(cfg_ready_q), .save_busy_q(save_busy_q)
  );
  nv_store_model u_nv (
    .mclk(mclk), .rst_b(rst_b), .nv_req(nv_req_q), .nv_we(nv_we_q), .nv_addr(nv_addr_q),
    .nv_wdata(nv_wdata_q), .slow(slow), .nv_ack(nv_ack), .nv_rdata(nv_rdata)
  );

  // free-running clock
  initial begin
    forever #2 mclk = ~mclk;
  end

  // category of each object, kept apart from the block's own table
  function automatic int cat_of(input int i);
    return (i == 0 || i == 15) ? 0 : i < 4 ? 1 : i < 8 ? 2 : i < 10 ? 3 : i < 12 ? 4 : 5;
  endfunction : cat_of

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // one save-command access; the answer stands one cycle after the strobe
  task automatic cmd_access(input logic wr, input logic [7:0] sub, input logic [31:0] val);
    @(posedge mclk);
    cmd_wr <= wr;
    cmd_rd <= ~wr;
    cmd_sub <= sub;
    cmd_wdata <= val;
    @(posedge mclk);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    #1 rd = cmd_rdata_q;
    check(cmd_ack_q, 32'h1);
  endtask : cmd_access

  // bounded wait: for the end of restore, or for the save engine to go idle
  task automatic wait_flag(input logic busy);
    int n;
    n = 0;
    while ((busy ? save_busy_q : ~cfg_ready_q) !== 1'b0) begin
      // sample a settled value, never in the time step of the launching edge
      @(posedge mclk);
      #1;
      n++;
      if (n > 3000) begin
        err_total++;
        wrap_up();
      end
    end
  endtask : wait_flag

  // live objects after reset come from storage, uncategorised ones start at zero
  task automatic restore_check;
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      obj_idx <= 4'(i);
      app_idx <= 4'(i);
      @(posedge mclk);
      #1 check(obj_rdata_q, cat_of(i) != 0 ? exp_mem[i] : 32'h0);
      check(app_data_q, cat_of(i) inside {0, 3} ? 32'h0 : exp_mem[i]);
      check(u_nv.mem[i], exp_mem[i]);
    end
  endtask : restore_check

  // fill every live object, save one subindex, poll until it reads one
  task automatic save_cat(input int s);
    int n;
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      obj_wr <= 1'b1;
      obj_idx <= 4'(i);
      obj_wdata <= {8'ha5, 8'(s), 16'(i)};
      if (cat_of(i) != 0 && (s == 1 || cat_of(i) == s - 1)) exp_mem[i] = {8'ha5, 8'(s), 16'(i)};
    end
    @(posedge mclk);
    obj_wr <= 1'b0;
    slow <= s[0]; // odd subindices meet a slow store
    cmd_access(1'b1, 8'(s), `SAVE_KEY);
    check(save_busy_q, 32'h1);
    n = 0;
    do begin
      cmd_access(1'b0, 8'(s), 32'h0);
      n++;
    end while (rd !== `SAVE_DONE_VAL && n < 1000);
    check(rd, `SAVE_DONE_VAL);
    // a save that never ends has already counted a mismatch, so stop here
    if (rd !== `SAVE_DONE_VAL) wrap_up();
    wait_flag(1'b1);
    for (int i = 0; i < 16; i++) check(u_nv.mem[i], exp_mem[i]);
  endtask : save_cat

  initial begin
    for (int i = 0; i < 16; i++) exp_mem[i] = 32'h5a5a0000 + i;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    // restore needs far more than two cycles, so the block is not ready yet
    repeat (2) @(posedge mclk);
    #1 check(cfg_ready_q, 32'h0);
    wait_flag(1'b0);
    restore_check();
    for (int s = 0; s < 8; s++) begin
      cmd_access(1'b0, 8'(s), 32'h0);
      check(rd, `CMD_RESET_VAL);
    end
    // a wrong value and an unmapped subindex start nothing
    cmd_access(1'b1, `SUB_COMM, 32'h12345678);
    cmd_access(1'b1, 8'h07, `SAVE_KEY);
    cmd_access(1'b0, 8'h07, 32'h0);
    check(rd, 32'h0);
    for (int c = 0; c < 20; c++) begin
      @(posedge mclk);
      #1 check(nv_req_q, 32'h0);
    end
    cmd_access(1'b0, `SUB_COMM, 32'h0);
    check(rd, 32'h12345678);
    foreach (subs[k]) save_cat(subs[k]);
    // motor setup writes a drive object, a comm object is refused, then it saves
    @(posedge mclk);
    setup_wr <= 1'b1;
    setup_idx <= 4'ha;
    setup_wdata <= 32'h0badf00d;
    @(posedge mclk);
    setup_idx <= 4'h1;
    setup_wdata <= 32'h0000dead;
    @(posedge mclk);
    setup_wr <= 1'b0;
    setup_save <= 1'b1;
    @(posedge mclk);
    setup_save <= 1'b0;
    exp_mem[10] = 32'h0badf00d;
    repeat (3) @(posedge mclk);
    wait_flag(1'b1);
    check(u_nv.mem[10], exp_mem[10]);
    check(u_nv.mem[1], exp_mem[1]);
    // the refused setup write must not have reached the live comm object either
    @(posedge mclk);
    obj_idx <= 4'h1;
    @(posedge mclk);
    #1 check(obj_rdata_q, exp_mem[1]);
    // a second reset restores everything that was saved
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 check(cfg_ready_q, 32'h0);
    wait_flag(1'b0);
    restore_check();
    wrap_up();
  end
endmodule : category_config_save_tb
`default_nettype wire
